/* File: hall_model.sv */
// hall sensor model: three position pins that follow a commanded pattern
// assumes the bench sets the pattern; the pins settle a few ns later, off any edge
`default_nettype none
module hall_model
(
  input wire logic [2:0] target_i,
  output logic [2:0] pins_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // start on a legal pattern, then follow after a sensor delay
  initial pins_o = 3'h1;
  always @(target_i)
    pins_o <= #3 target_i;
endmodule : hall_model
`default_nettype wire

/* File: hall_pkg.sv */
// constants, field layout and codes for the hall sensor commutation block
// assumes a 16-bit register port with byte addresses on word boundaries
`default_nettype none
package hall_pkg;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int NODES = 4;
  localparam int NODE_W = 2;
  localparam int MODE_W = 4;
  localparam int PAT_W = 3;
  localparam int MOD_W = 6;
  localparam logic [MODE_W-1:0] CH_HALL = 4'h8;
  // register byte offsets
  localparam logic [AW-1:0] OFF_MODE = 8'h00;
  localparam logic [AW-1:0] OFF_CHMODE = 8'h04;
  localparam logic [AW-1:0] OFF_SWITCH = 8'h08;
  localparam logic [AW-1:0] OFF_DELAY = 8'h0C;
  localparam logic [AW-1:0] OFF_SHADOW = 8'h10;
  localparam logic [AW-1:0] OFF_ACTIVE = 8'h14;
  localparam logic [AW-1:0] OFF_STATUS = 8'h18;
  localparam logic [AW-1:0] OFF_FSET = 8'h1C;
  localparam logic [AW-1:0] OFF_FCLR = 8'h20;
  localparam logic [AW-1:0] OFF_IRQ = 8'h24;
  localparam logic [AW-1:0] OFF_PERIOD = 8'h28;
  localparam logic [AW-1:0] OFF_CAPT = 8'h2C;
  localparam logic [AW-1:0] OFF_CH1 = 8'h30;
  localparam logic [AW-1:0] OFF_CH2 = 8'h34;
  localparam logic [AW-1:0] OFF_COUNT = 8'h38;
  // field positions
  localparam int F_TRIG = 0;
  localparam int F_BYP = 3;
  localparam int F_HALTEN = 4;
  localparam int F_RUN = 5;
  localparam int F_CENTER = 6;
  localparam int F_SWITCHING_EVENT_SELECT = 0;
  localparam int F_SWITCHING_SYNC_SELECT = 4;
  localparam int F_SWITCHING_EVENT_ENABLE = 8;
  localparam int F_CUR = 0;
  localparam int F_EXP = 3;
  localparam int F_MOD = 6;
  localparam int F_HREQ = 14;
  localparam int F_MREQ = 15;
  localparam int F_HALT = 3;
  localparam int F_SAMP = 4;
  localparam int F_POS = 7;
  localparam int F_REM = 10;
  localparam int F_NODE = 4;
  // sampling trigger codes
  typedef enum logic [2:0] {TRG_EDGE = 3'h0, TRG_AUX_CM = 3'h1, TRG_AUX_PM = 3'h2, TRG_OFF = 3'h3,
    TRG_PM_UP = 3'h4, TRG_OM_DN = 3'h5, TRG_CH1_UP = 3'h6, TRG_CH1_DN = 3'h7} trig_t;
  // switching event and synchronisation codes
  typedef enum logic [2:0] {SW_NONE = 3'h0, SW_CORRECT = 3'h1, SW_AUX_PM = 3'h2, SW_OM_DN = 3'h3,
    SW_CH1_UP = 3'h4, SW_PM_UP = 3'h5, SW_RES6 = 3'h6, SW_RES7 = 3'h7} sw_t;
  typedef enum logic [1:0] {SYN_DIRECT = 2'h0, SYN_AUX_ZM = 2'h1, SYN_MAIN_ZM = 2'h2, SYN_RES = 2'h3} syn_t;
  typedef enum logic [2:0] {ST_WAIT = 3'h1, ST_DELAY = 3'h2, ST_EVAL = 3'h4} eval_state_t;
endpackage : hall_pkg
`default_nettype wire

/* File: hall_sensor_commutation.sv */
// hall sensor evaluation, pattern shadows, flags, halt and main timer motor mode
// assumes aux timer events come from logic on clock_i; position inputs are pins
//
// Operation
// RL1 - input n maps to pattern bit n
// RL2 - delay filter runs dead-time counter then ready
// RL3 - delay filter blocks main pwm modulation
// RL4 - compare ready samples and starts evaluation
// RL5 - trigger codes 000 to 011 select source
// RL6 - trigger codes 100 to 111 use main timer
// RL7 - sample equal current pattern is spike
// RL8 - sample equal expected pattern is correct event
// RL9 - neither match gives wrong event
// RL10 - correct event copies hall shadows to active
// RL11 - software requests force hall or modulation copy
// RL12 - correct flag set, enable, node, clear
// RL13 - wrong flag handled like correct flag
// RL14 - modulation transfer sets transfer flag
// RL15 - every set event raises a request
// RL16 - halt set by wrong event or software
// RL17 - halt forces passive pattern until cleared
// RL18 - software requests both transfers to resume
// RL19 - motor mode: capture, phase delay, time-out
// RL20 - correct event loads shadows, captures, clears timer
// RL21 - no normal shadow transfer; stopped writes both
// RL22 - channel 1 match triggers modulation transfer
// RL23 - switching code 001 uses correct event
// RL24 - sync code 00 transfers directly
// RL25 - position inputs pass two flip-flops
//
// Added by the designer: the placing of the registers and strobed register access.
`default_nettype none
module hall_sensor_commutation
  import hall_pkg::*;
#(
  parameter int DELAY_W = 8
)
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DW-1:0] rdata_o,
  input wire logic [PAT_W-1:0] position_inputs_i,
  input wire logic aux_compare_match_i,
  input wire logic aux_period_match_i,
  input wire logic aux_zero_match_i,
  output logic [MOD_W-1:0] active_modulation_pattern_o,
  output logic correct_position_event_o,
  output logic wrong_position_event_o,
  output logic compare_ready_o,
  output logic main_pwm_block_o,
  output logic timeout_o,
  output logic period_timeout_o,
  output logic [NODES-1:0] irq_node_o
);
  // ****************************************
  // configuration and shadow registers
  // ****************************************
  trig_t trig_sel;
  sw_t sw_sel;
  syn_t sw_syn;
  eval_state_t state;
  eval_state_t next_state;
  logic bypass, halt_en, timer_run, center_mode, sw_en;
  logic [3*MODE_W-1:0] chan_mode;
  logic [DELAY_W-1:0] delay_len, delay_cnt;
  logic [PAT_W-1:0] cur_sh, exp_sh, cur_pat, exp_pat, sampled;
  logic [MOD_W-1:0] mod_sh, act_mod;
  logic [2:0] irq_en, flag, set_vec, clr_vec;
  logic [3*NODE_W-1:0] node_sel;
  logic halt, reminder;
  logic [DW-1:0] count, period_sh, period, ch1_sh, ch1, ch2_sh, ch2, capture0;
  logic dir_down;
  logic [PAT_W-1:0] pos_meta, pos_sync, pos_prev;
  logic [2:0] sync_fill;

  // write strobes per register
  logic wr_mode, wr_chmode, wr_switch, wr_delay, wr_pat, wr_fset, wr_fclr, wr_irq;
  logic wr_period, wr_ch1, wr_ch2, wr_count;
  assign wr_mode = wr_i && addr_i == OFF_MODE;
  assign wr_chmode = wr_i && addr_i == OFF_CHMODE;
  assign wr_switch = wr_i && addr_i == OFF_SWITCH;
  assign wr_delay = wr_i && addr_i == OFF_DELAY;
  assign wr_pat = wr_i && addr_i == OFF_SHADOW;
  assign wr_fset = wr_i && addr_i == OFF_FSET;
  assign wr_fclr = wr_i && addr_i == OFF_FCLR;
  assign wr_irq = wr_i && addr_i == OFF_IRQ;
  assign wr_period = wr_i && addr_i == OFF_PERIOD;
  assign wr_ch1 = wr_i && addr_i == OFF_CH1;
  assign wr_ch2 = wr_i && addr_i == OFF_CH2;
  assign wr_count = wr_i && addr_i == OFF_COUNT;

  // control registers
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      trig_sel <= TRG_EDGE;
      bypass <= 1'b0;
      halt_en <= 1'b0;
      timer_run <= 1'b0;
      center_mode <= 1'b0;
      chan_mode <= '0;
      sw_sel <= SW_NONE;
      sw_syn <= SYN_DIRECT;
      sw_en <= 1'b0;
      delay_len <= '0;
      irq_en <= '0;
      node_sel <= '0;
    end
    else
    begin
      if (wr_mode)
      begin
        trig_sel <= trig_t'(wdata_i[F_TRIG +: 3]);
        bypass <= wdata_i[F_BYP];
        halt_en <= wdata_i[F_HALTEN];
        timer_run <= wdata_i[F_RUN];
        center_mode <= wdata_i[F_CENTER];
      end
      if (wr_chmode)
        chan_mode <= wdata_i[3*MODE_W-1:0];
      if (wr_switch)
      begin
        sw_sel <= sw_t'(wdata_i[F_SWITCHING_EVENT_SELECT +: 3]);
        sw_syn <= syn_t'(wdata_i[F_SWITCHING_SYNC_SELECT +: 2]);
        sw_en <= wdata_i[F_SWITCHING_EVENT_ENABLE];
      end
      if (wr_delay)
        delay_len <= wdata_i[DELAY_W-1:0];
      if (wr_irq)
      begin
        irq_en <= wdata_i[2:0];
        node_sel <= wdata_i[F_NODE +: 3*NODE_W];
      end
    end
  end

  // ****************************************
  // input synchronisation and triggers
  // ****************************************
  // RL25 two-stage synchroniser
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pos_meta <= '0;
      pos_sync <= '0;
      pos_prev <= '0;
      sync_fill <= '0;
    end
    else
    begin
      pos_meta <= position_inputs_i;
      pos_sync <= pos_meta;
      pos_prev <= pos_sync;
      // marks when the pipeline holds real pin levels, so no false edge follows reset
      sync_fill <= {sync_fill[1:0], 1'b1};
    end
  end

  // mode decode and timer matches
  logic motor_mode, delay_mode, period_m, one_m, zero_m, ch1_m, ch2_m, trig_hit;
  assign motor_mode = chan_mode == {3{CH_HALL}};
  // RL2 delay filter mode
  assign delay_mode = motor_mode && !bypass;
  // RL3 pwm modulation blocked
  assign main_pwm_block_o = delay_mode;
  assign period_m = timer_run && count == period;
  assign one_m = timer_run && count == 16'h0001;
  assign zero_m = timer_run && count == 16'h0000;
  assign ch1_m = timer_run && count == ch1;
  assign ch2_m = timer_run && count == ch2;

  // sampling trigger select
  always_comb
  begin
    unique case (trig_sel)
      // RL5 edge and aux sources
      TRG_EDGE: trig_hit = sync_fill[2] && |(pos_sync ^ pos_prev);
      TRG_AUX_CM: trig_hit = aux_compare_match_i;
      TRG_AUX_PM: trig_hit = aux_period_match_i;
      TRG_OFF: trig_hit = 1'b0;
      // RL6 main timer sources
      TRG_PM_UP: trig_hit = period_m && !dir_down;
      TRG_OM_DN: trig_hit = one_m && dir_down;
      TRG_CH1_UP: trig_hit = ch1_m && !dir_down;
      TRG_CH1_DN: trig_hit = ch1_m && dir_down;
    endcase
  end

  // ****************************************
  // delay filter and pattern compare
  // ****************************************
  logic compare_ready, is_spike, correct_evt, wrong_evt;
  // RL2 ready after delay
  assign compare_ready = (state == ST_WAIT && trig_hit && !delay_mode) || (state == ST_DELAY && delay_cnt == '0);

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_WAIT:
        if (trig_hit)
          next_state = delay_mode ? ST_DELAY : ST_EVAL;
      ST_DELAY:
        if (delay_cnt == '0)
          next_state = ST_EVAL;
      ST_EVAL: next_state = ST_WAIT;
      default: next_state = ST_WAIT;
    endcase
  end

  // evaluation state, dead-time counter, sample
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= ST_WAIT;
      delay_cnt <= '0;
      sampled <= '0;
    end
    else
    begin
      state <= next_state;
      // RL2 start dead-time counter
      if (state == ST_WAIT && trig_hit && delay_mode)
        delay_cnt <= delay_len;
      else if (state == ST_DELAY && delay_cnt != '0)
        delay_cnt <= delay_cnt - 1'b1;
      // RL4 RL1 sample inputs in bit order
      if (compare_ready)
        sampled <= pos_sync;
    end
  end

  // RL7 spike filtered out
  assign is_spike = sampled == cur_pat;
  // RL8 correct position event
  assign correct_evt = state == ST_EVAL && !is_spike && sampled == exp_pat;
  // RL9 wrong position event
  assign wrong_evt = state == ST_EVAL && !is_spike && sampled != exp_pat;

  // ****************************************
  // shadow transfers and halt
  // ****************************************
  logic hall_xfer, sw_evt, mod_xfer, sync_hit, halt_set, halt_clr;
  logic [PAT_W-1:0] src_cur, src_exp;
  logic [MOD_W-1:0] src_mod;
  // a request written with new shadow contents copies the new contents
  assign src_cur = wr_pat ? wdata_i[F_CUR +: PAT_W] : cur_sh;
  assign src_exp = wr_pat ? wdata_i[F_EXP +: PAT_W] : exp_sh;
  assign src_mod = wr_pat ? wdata_i[F_MOD +: MOD_W] : mod_sh;
  // RL10 RL11 hall pattern transfer
  assign hall_xfer = correct_evt || (wr_pat && wdata_i[F_HREQ]);

  // switching event select
  always_comb
  begin
    unique case (sw_sel)
      // RL23 correct event, no delay
      SW_CORRECT: sw_evt = correct_evt;
      SW_AUX_PM: sw_evt = aux_period_match_i;
      SW_OM_DN: sw_evt = one_m && dir_down;
      // RL22 phase delay match
      SW_CH1_UP: sw_evt = ch1_m && !dir_down;
      SW_PM_UP: sw_evt = period_m && !dir_down;
      default: sw_evt = 1'b0;
    endcase
    sw_evt = sw_evt && sw_en;
  end

  // switching synchronisation
  always_comb
  begin
    unique case (sw_syn)
      // RL24 direct transfer
      SYN_DIRECT: sync_hit = sw_evt || reminder;
      SYN_AUX_ZM: sync_hit = aux_zero_match_i && (sw_evt || reminder);
      SYN_MAIN_ZM: sync_hit = zero_m && (sw_evt || reminder);
      default: sync_hit = 1'b0;
    endcase
  end
  // RL11 software modulation request
  assign mod_xfer = sync_hit || (wr_pat && wdata_i[F_MREQ]);
  // RL16 halt set sources
  assign halt_set = (wrong_evt && halt_en) || (wr_fset && wdata_i[F_HALT]);
  assign halt_clr = wr_fclr && wdata_i[F_HALT];

  // pattern shadows, active patterns, reminder, halt
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cur_sh <= '0;
      exp_sh <= '0;
      mod_sh <= '0;
      cur_pat <= '0;
      exp_pat <= '0;
      act_mod <= '0;
      reminder <= 1'b0;
      halt <= 1'b0;
    end
    else
    begin
      if (wr_pat)
      begin
        cur_sh <= src_cur;
        exp_sh <= src_exp;
        mod_sh <= src_mod;
      end
      // RL10 copy hall patterns
      if (hall_xfer)
      begin
        cur_pat <= src_cur;
        exp_pat <= src_exp;
      end
      // RL17 halt holds pattern passive; RL18 resume via requests
      if (halt)
        act_mod <= '0;
      else if (mod_xfer)
        act_mod <= src_mod;
      reminder <= (sw_evt || reminder) && !mod_xfer;
      // RL17 halt set wins over clear
      halt <= halt_set || (halt && !halt_clr);
    end
  end

  // ****************************************
  // event flags and node requests
  // ****************************************
  // RL12 RL13 RL14 flag set sources
  assign set_vec = {mod_xfer, wrong_evt, correct_evt} | (wr_fset ? wdata_i[2:0] : 3'h0);
  assign clr_vec = wr_fclr ? wdata_i[2:0] : 3'h0;

  // flags, set wins over clear
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      flag <= '0;
    else
      flag <= set_vec | (flag & ~clr_vec);
  end

  // RL15 RL12 request per set event to chosen node
  for (genvar n = 0; n < NODES; n++)
  begin : g_node
    logic hit;
    always_comb
    begin
      hit = 1'b0;
      for (int f = 0; f < 3; f++)
        if (set_vec[f] && irq_en[f] && node_sel[f*NODE_W +: NODE_W] == NODE_W'(n))
          hit = 1'b1;
    end
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
      if (!nrst_i)
        irq_node_o[n] <= 1'b0;
      else
        irq_node_o[n] <= hit;
    end
  end

  // ****************************************
  // main timer
  // ****************************************
  logic normal_st, motor_st;
  // RL21 normal shadow transfer only outside motor mode
  assign normal_st = !motor_mode && (center_mode ? zero_m && dir_down : period_m);
  // RL20 motor mode transfer on correct event
  assign motor_st = motor_mode && correct_evt;

  // counter, shadows and active compare values
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      count <= '0;
      dir_down <= 1'b0;
      period_sh <= '0;
      period <= '0;
      ch1_sh <= '0;
      ch1 <= '0;
      ch2_sh <= '0;
      ch2 <= '0;
      capture0 <= '0;
    end
    else
    begin
      if (motor_st)
      begin
        // RL20 RL19 capture speed then clear
        capture0 <= count;
        count <= '0;
        dir_down <= 1'b0;
      end
      else if (wr_count && !timer_run)
        count <= wdata_i;
      else if (timer_run && dir_down)
      begin
        dir_down <= !zero_m;
        count <= zero_m ? count + 1'b1 : count - 1'b1;
      end
      else if (period_m)
      begin
        dir_down <= center_mode;
        count <= center_mode ? count - 1'b1 : '0;
      end
      else if (timer_run)
        count <= count + 1'b1;
      if (wr_period)
        period_sh <= wdata_i;
      if (wr_ch1)
        ch1_sh <= wdata_i;
      if (wr_ch2)
        ch2_sh <= wdata_i;
      // RL21 stopped write reaches both
      if (motor_st || normal_st)
      begin
        period <= period_sh;
        ch1 <= ch1_sh;
        ch2 <= ch2_sh;
      end
      else if (!timer_run)
      begin
        if (wr_period)
          period <= wdata_i;
        if (wr_ch1)
          ch1 <= wdata_i;
        if (wr_ch2)
          ch2 <= wdata_i;
      end
    end
  end

  // ****************************************
  // outputs and read port
  // ****************************************
  // registered event and time-out outputs
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      correct_position_event_o <= 1'b0;
      wrong_position_event_o <= 1'b0;
      compare_ready_o <= 1'b0;
      timeout_o <= 1'b0;
      period_timeout_o <= 1'b0;
    end
    else
    begin
      correct_position_event_o <= correct_evt;
      wrong_position_event_o <= wrong_evt;
      compare_ready_o <= compare_ready;
      // RL19 channel 2 and period time-outs
      timeout_o <= motor_mode && ch2_m;
      period_timeout_o <= motor_mode && period_m;
    end
  end
  assign active_modulation_pattern_o = act_mod;

  // read data one cycle after strobe, zero otherwise
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= '0;
    else if (!rd_i)
      rdata_o <= '0;
    else
    begin
      unique case (addr_i)
        OFF_MODE: rdata_o <= DW'({center_mode, timer_run, halt_en, bypass, trig_sel});
        OFF_CHMODE: rdata_o <= DW'(chan_mode);
        OFF_SWITCH: rdata_o <= DW'({sw_en, 2'h0, sw_syn, 1'b0, sw_sel});
        OFF_DELAY: rdata_o <= DW'(delay_len);
        OFF_SHADOW: rdata_o <= DW'({mod_sh, exp_sh, cur_sh});
        OFF_ACTIVE: rdata_o <= DW'({act_mod, exp_pat, cur_pat});
        OFF_STATUS: rdata_o <= DW'({reminder, pos_sync, sampled, halt, flag});
        OFF_IRQ: rdata_o <= DW'({node_sel, 1'b0, irq_en});
        OFF_PERIOD: rdata_o <= period;
        OFF_CAPT: rdata_o <= capture0;
        OFF_CH1: rdata_o <= ch1;
        OFF_CH2: rdata_o <= ch2;
        OFF_COUNT: rdata_o <= count;
        default: rdata_o <= '0;
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  // RL1 sample bit order
  sample_order_a: assert property (compare_ready |=> sampled == $past(pos_sync)) // RL1
    else $error("sample does not follow inputs");
  // RL2 delay counter start
  delay_start_a: assert property (state == ST_WAIT && trig_hit && delay_mode
    |=> state == ST_DELAY && delay_cnt == $past(delay_len)) // RL2
    else $error("dead-time counter not started");
  // RL4 ready leads to evaluation
  ready_eval_a: assert property (compare_ready |=> state == ST_EVAL ##1 state == ST_WAIT) // RL4
    else $error("evaluation not started");
  // RL7 spike gives nothing
  spike_quiet_a: assert property (state == ST_EVAL && is_spike
    |=> !correct_position_event_o && !wrong_position_event_o) // RL7
    else $error("spike produced an event");
  // RL8 correct event flag
  correct_flag_a: assert property (correct_evt |=> correct_position_event_o && flag[0]) // RL8
    else $error("correct event lost");
  // RL9 wrong event flag
  wrong_flag_a: assert property (state == ST_EVAL && sampled != cur_pat && sampled != exp_pat
    |=> wrong_position_event_o && flag[1]) // RL9
    else $error("wrong event lost");
  // RL10 hall pattern copy
  hall_copy_a: assert property (correct_evt && !wr_pat
    |=> cur_pat == $past(cur_sh) && exp_pat == $past(exp_sh)) // RL10
    else $error("hall patterns not copied");
  // RL15 request while flag set
  irq_rearm_a: assert property (correct_evt && flag[0] && irq_en[0]
    |=> irq_node_o[$past(node_sel[NODE_W-1:0])]) // RL15
    else $error("request not re-raised");
  // RL16 halt on wrong event
  halt_set_a: assert property (wrong_evt && halt_en |=> halt) // RL16
    else $error("halt not set");
  // RL17 passive while halted
  halt_passive_a: assert property (halt && $past(halt) |-> act_mod == '0) // RL17
    else $error("pattern active during halt");
  // RL20 capture and clear
  capture_clear_a: assert property (motor_st |=> count == '0 && capture0 == $past(count)) // RL20
    else $error("capture or clear missing");
  // RL22 phase delay switch
  phase_switch_a: assert property (sw_sel == SW_CH1_UP && sw_syn == SYN_DIRECT && sw_en && ch1_m
    && !dir_down && !halt && !wr_pat |=> act_mod == $past(mod_sh) && flag[2]) // RL22
    else $error("phase delay transfer missing");

  correct_seen_c: cover property (correct_evt ##[1:50] correct_evt);
  wrong_halt_c: cover property (wrong_evt && halt_en ##1 halt);
  delay_path_c: cover property (state == ST_DELAY ##1 compare_ready);
endmodule : hall_sensor_commutation
`default_nettype wire

/* File: hall_sensor_commutation_tb.sv */
// self-checking bench for the hall sensor commutation block
// assumes hall_pkg and hall_model; one 100 MHz clock, register port per hand-over
`default_nettype none
module hall_sensor_commutation_tb
  import hall_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [AW-1:0] addr_i = '0;
  logic [DW-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic aux_cm = 1'b0;
  logic aux_pm = 1'b0;
  logic aux_zm = 1'b0;
  logic [2:0] target = 3'h1;
  logic [2:0] pins;
  logic [DW-1:0] rdata_o;
  logic [MOD_W-1:0] mod_o;
  logic ok_o;
  logic bad_o;
  logic block_o;
  logic [NODES-1:0] irq_o;
  logic rdy_o;
  logic to_o;
  logic pto_o;
  int n_rdy = 0;
  int n_to = 0;
  int n_pto = 0;
  logic [DW-1:0] d;
  int n_errors = 0;
  int samples_checked = 0;
  int n_ok = 0;
  int n_bad = 0;
  int n_irq = 0;

  hall_model partner (.target_i(target), .pins_o(pins));
  hall_sensor_commutation dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .position_inputs_i(pins), .aux_compare_match_i(aux_cm),
    .aux_period_match_i(aux_pm), .aux_zero_match_i(aux_zm), .active_modulation_pattern_o(mod_o),
    .correct_position_event_o(ok_o), .wrong_position_event_o(bad_o), .compare_ready_o(rdy_o),
    .main_pwm_block_o(block_o), .timeout_o(to_o), .period_timeout_o(pto_o), .irq_node_o(irq_o));

  // ************************************************
  // clock, event counters and shared tasks
  // ************************************************
  initial
  begin
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    n_ok += (ok_o === 1'b1);
    n_bad += (bad_o === 1'b1);
    n_irq += (irq_o[1] === 1'b1);
    n_rdy += (rdy_o === 1'b1);
    n_to += (to_o === 1'b1);
    n_pto += (pto_o === 1'b1);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    // let the write settle before any output is looked at
    #1;
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task automatic aux_pulse();
    @(posedge clock_i);
    aux_cm <= 1'b1;
    @(posedge clock_i);
    aux_cm <= 1'b0;
    repeat (8) @(posedge clock_i);
  endtask : aux_pulse
  task automatic test_done();
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_force();
    rd(OFF_ACTIVE, d); chk(d, 16'h0000);
    wr(OFF_SHADOW, 16'hC559);
    rd(OFF_ACTIVE, d); chk(d, 16'h0559);
    chk({10'h000, mod_o}, 16'h0015);
    rd(OFF_STATUS, d); chk(d & 16'h000F, 16'h0004);
  endtask : t_force
  task automatic t_correct();
    wr(OFF_MODE, 16'h0010);
    wr(OFF_SHADOW, 16'h0A93);
    target = 3'h3;
    repeat (12) @(posedge clock_i);
    chk(16'(n_ok), 16'h0001);
    rd(OFF_ACTIVE, d); chk(d, 16'h0553);
    rd(OFF_STATUS, d); chk(d & 16'h03FF, 16'h01B5);
  endtask : t_correct
  task automatic t_wrong();
    wr(OFF_IRQ, 16'h0042);
    wr(OFF_MODE, 16'h0011);
    aux_pulse();
    chk(16'(n_ok + n_bad), 16'h0001);
    target = 3'h6;
    repeat (8) @(posedge clock_i);
    chk(16'(n_bad), 16'h0000);
    aux_pulse();
    chk(16'(n_bad), 16'h0001);
    chk({10'h000, mod_o}, 16'h0000);
    rd(OFF_STATUS, d); chk(d & 16'h000F, 16'h000F);
    chk(16'(n_irq), 16'h0001);
    wr(OFF_FSET, 16'h0002);
    repeat (3) @(posedge clock_i);
    chk(16'(n_irq), 16'h0002);
  endtask : t_wrong
  task automatic t_resume();
    wr(OFF_FCLR, 16'h0008);
    rd(OFF_STATUS, d); chk(d & 16'h0008, 16'h0000);
    chk({10'h000, mod_o}, 16'h0000);
    // software restart with both transfers
    wr(OFF_SHADOW, 16'hC6B3);
    chk({10'h000, mod_o}, 16'h001A);
    rd(OFF_ACTIVE, d); chk(d, 16'h06B3);
  endtask : t_resume
  task automatic t_mode();
    wr(OFF_CHMODE, 16'h0888);
    chk({15'h0000, block_o}, 16'h0001);
    wr(OFF_MODE, 16'h0008);
    chk({15'h0000, block_o}, 16'h0000);
  endtask : t_mode
  // delay filter, motor mode capture, phase delay switch and time-outs
  task automatic t_motor();
    wr(OFF_DELAY, 16'h0004);
    wr(OFF_PERIOD, 16'h0100);
    wr(OFF_CH1, 16'h0020);
    wr(OFF_CH2, 16'h0030);
    rd(OFF_CH1, d); chk(d, 16'h0020);
    wr(OFF_SWITCH, 16'h0104);
    wr(OFF_SHADOW, 16'h4026);
    wr(OFF_SHADOW, 16'h0B6C);
    wr(OFF_MODE, 16'h0020);
    target = 3'h4;
    repeat (70) @(posedge clock_i);
    chk(16'(n_ok), 16'h0002);
    chk(16'(n_to), 16'h0001);
    rd(OFF_CAPT, d); chk(d, 16'h0008);
    rd(OFF_ACTIVE, d); chk(d, 16'h0B6C);
    repeat (200) @(posedge clock_i);
    chk(16'(n_pto), 16'h0001);
    chk(16'(n_rdy), 16'h0004);
  endtask : t_motor

  // ************************************************
  // main sequence and watchdog
  // ************************************************
  initial
  begin
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_force();
    t_correct();
    t_wrong();
    t_resume();
    t_mode();
    t_motor();
    test_done();
  end
  initial
  begin
    #50000;
    n_errors++;
    test_done();
  end
endmodule : hall_sensor_commutation_tb
`default_nettype wire
